// ==== rtl/dpt_pkg.sv ====
/*
  Shared constants, frame layout and state list for the data-transfer sequencer.
  Assumes one 200 MHz clock, an APB master for software and a transport layer
  on the same clock.
*/
// Operation
// - PIO read: on command or more blocks, prepare block, then go to setup.
// - PIO read abort while preparing goes to the error-status state.
// - PIO read setup frame: initial busy 0, data-request 1, interrupt set.
// - PIO read setup end status: both clear on last block, else busy only.
// - After PIO read setup frame, send a data frame with the block.
// - After read data frame: idle when all moved, else prepare next block.
// - PIO write: on command or more blocks, prepare to accept, then setup.
// - PIO write: all received or abort goes to the send-status state.
// - PIO write setup: busy 0, data-request 1, interrupt clear only first block.
// - PIO write setup end status busy set, data-request clear, block byte count.
// - Host sends data frame after write setup; receipt returns to preparation.
// - Status states send register frame with interrupt set, idle when sent.
// - DMA read: on command or more frames, prepare data, then send state.
// - DMA read send: data frame of at most 8KB, then back to preparation.
// - DMA read: all moved or abort goes from preparation to send-status.
package dpt_pkg;
  localparam int FIS_MAX_BYTES = 8192;
  localparam int LEN_W = 14;
  // register byte addresses
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_LENGTH = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_REMAIN = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK = 8'h14;
  // interrupt status bits
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ABORT_BIT = 1;
  localparam int INT_W = 2;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 2'h0;
  localparam logic [31:0] LENGTH_RESET = 32'h0;

  typedef enum logic [1:0] {
    CMD_NONE, CMD_PIO_READ, CMD_PIO_WRITE, CMD_DMA_READ
  } dpt_cmd_t;

  typedef enum logic [1:0] {
    FIS_NONE, FIS_PIO_SETUP, FIS_DATA, FIS_REGISTER
  } dpt_fis_t;

  typedef enum {
    device_idle_state,
    pio_read_prepare_state, pio_read_setup_state, pio_read_transmit_state,
    pio_read_error_state,
    pio_write_prepare_state, pio_write_setup_state, pio_write_receive_state,
    pio_write_status_state,
    dma_read_prepare_state, dma_read_send_state, dma_read_status_state
  } dpt_state_t;

  // one frame request toward the transport layer
  typedef struct packed {
    logic valid;
    dpt_fis_t kind;
    logic initBusy;
    logic initDataReq;
    logic endBusy;
    logic endDataReq;
    logic interruptFlag;
    logic aborted;
    logic [LEN_W-1:0] byteCount;
  } dpt_frame_t;
endpackage

// ==== rtl/dpt_transfer_fsm.sv ====
/*
  Device-side sequencer for PIO read, PIO write and DMA read commands.
  Assumes: APB master on mclk; transport layer on mclk that pulses frameSent
  for a frame while txFrame.valid is high, and pulses dataReceived for an
  incoming data frame while rxExpect is high; blockReady and abortReq come
  from the device's own data path on mclk.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
module dpt_transfer_fsm
  import dpt_pkg::*;
#(
  parameter int MAX_BLOCK = FIS_MAX_BYTES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic blockReady,
  input wire logic abortReq,
  input wire logic frameSent,
  input wire logic dataReceived,
  output dpt_frame_t txFrame,
  output logic rxExpect,
  output logic irq
);
  localparam logic [LEN_W-1:0] MAX_LEN = LEN_W'(MAX_BLOCK);

  // refuse block limits that the length field or frame cap cannot serve
  if (MAX_BLOCK < 1 || MAX_BLOCK > FIS_MAX_BYTES) begin : gBadBlock
    $error("MAX_BLOCK must lie between 1 and 8192");
  end

  dpt_state_t state_q, state_d;
  logic [31:0] remain_q, remain_d;
  logic [LEN_W-1:0] blkLen_q, blkLen_d;
  logic first_q, first_d;
  logic abort_q, abort_d;
  logic [31:0] length_q;
  logic [INT_W-1:0] intStat_q, intMask_q, intEvent;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q, rxExpect_q;
  dpt_frame_t txFrame_q;
  logic apbAccess, apbWrite, startCmd, mapped;
  dpt_cmd_t cmdReq;

  // size of the next block: remaining bytes capped at the MAX_BLOCK block limit
  function automatic logic [LEN_W-1:0] blockOf(input logic [31:0] rem);
    blockOf = (rem > 32'(MAX_BLOCK)) ? MAX_LEN : rem[LEN_W-1:0];
  endfunction

  function automatic logic [31:0] lessBlock(input logic [31:0] rem,
                                            input logic [LEN_W-1:0] len);
    lessBlock = rem - 32'(len);
  endfunction

  assign apbAccess = psel & penable & pready_q;
  assign apbWrite = apbAccess & pwrite;
  assign cmdReq = dpt_cmd_t'(pwdata[1:0]);
  assign startCmd = apbWrite && paddr == ADDR_CMD && cmdReq != CMD_NONE
                    && length_q != 32'h0;
  assign mapped = paddr == ADDR_CMD || paddr == ADDR_LENGTH || paddr == ADDR_STATE
                  || paddr == ADDR_REMAIN || paddr == ADDR_INT_STAT
                  || paddr == ADDR_INT_MASK;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    remain_d = remain_q;
    blkLen_d = blkLen_q;
    first_d = first_q;
    abort_d = abort_q;
    intEvent = '0;
    case (state_q)
      device_idle_state: begin
        if (startCmd) begin
          remain_d = length_q;
          first_d = 1'b1;
          abort_d = 1'b0;
          case (cmdReq)
            CMD_PIO_READ: state_d = pio_read_prepare_state;
            CMD_PIO_WRITE: state_d = pio_write_prepare_state;
            default: state_d = dma_read_prepare_state;
          endcase
        end
      end
      pio_read_prepare_state: begin
        if (abortReq) begin
          abort_d = 1'b1;
          state_d = pio_read_error_state;
        end else if (blockReady) begin
          blkLen_d = blockOf(remain_q);
          state_d = pio_read_setup_state;
        end
      end
      pio_read_setup_state: begin
        if (frameSent) begin
          state_d = pio_read_transmit_state;
        end
      end
      pio_read_transmit_state: begin
        if (frameSent) begin
          remain_d = lessBlock(remain_q, blkLen_q);
          first_d = 1'b0;
          if (remain_q == 32'(blkLen_q)) begin
            intEvent[INT_DONE_BIT] = 1'b1;
            state_d = device_idle_state;
          end else begin
            state_d = pio_read_prepare_state;
          end
        end
      end
      pio_write_prepare_state: begin
        if (abortReq || remain_q == 32'h0) begin
          abort_d = abortReq;
          state_d = pio_write_status_state;
        end else if (blockReady) begin
          blkLen_d = blockOf(remain_q);
          state_d = pio_write_setup_state;
        end
      end
      pio_write_setup_state: begin
        if (frameSent) begin
          state_d = pio_write_receive_state;
        end
      end
      pio_write_receive_state: begin
        if (dataReceived) begin
          remain_d = lessBlock(remain_q, blkLen_q);
          first_d = 1'b0;
          state_d = pio_write_prepare_state;
        end
      end
      dma_read_prepare_state: begin
        if (abortReq || remain_q == 32'h0) begin
          abort_d = abortReq;
          state_d = dma_read_status_state;
        end else if (blockReady) begin
          blkLen_d = blockOf(remain_q);
          state_d = dma_read_send_state;
        end
      end
      dma_read_send_state: begin
        if (frameSent) begin
          remain_d = lessBlock(remain_q, blkLen_q);
          first_d = 1'b0;
          state_d = dma_read_prepare_state;
        end
      end
      pio_read_error_state, pio_write_status_state, dma_read_status_state: begin
        if (frameSent) begin
          intEvent[INT_DONE_BIT] = ~abort_q;
          intEvent[INT_ABORT_BIT] = abort_q;
          state_d = device_idle_state;
        end
      end
      default: state_d = device_idle_state;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= device_idle_state;
      remain_q <= 32'h0;
      blkLen_q <= '0;
      first_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      blkLen_q <= blkLen_d;
      first_q <= first_d;
      abort_q <= abort_d;
    end
  end

  // frame request built from the coming state so it drops with frameSent
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txFrame_q <= '0;
      rxExpect_q <= 1'b0;
    end else begin
      txFrame_q <= '0;
      rxExpect_q <= state_d == pio_write_receive_state;
      case (state_d)
        pio_read_setup_state: begin
          txFrame_q.valid <= 1'b1;
          txFrame_q.kind <= FIS_PIO_SETUP;
          txFrame_q.initDataReq <= 1'b1;
          txFrame_q.interruptFlag <= 1'b1;
          txFrame_q.endBusy <= remain_d != 32'(blkLen_d);
          txFrame_q.byteCount <= blkLen_d;
        end
        pio_write_setup_state: begin
          txFrame_q.valid <= 1'b1;
          txFrame_q.kind <= FIS_PIO_SETUP;
          txFrame_q.initDataReq <= 1'b1;
          txFrame_q.interruptFlag <= ~first_d;
          txFrame_q.endBusy <= 1'b1;
          txFrame_q.byteCount <= blkLen_d;
        end
        pio_read_transmit_state, dma_read_send_state: begin
          txFrame_q.valid <= 1'b1;
          txFrame_q.kind <= FIS_DATA;
          txFrame_q.byteCount <= blkLen_d;
        end
        pio_read_error_state, pio_write_status_state, dma_read_status_state: begin
          txFrame_q.valid <= 1'b1;
          txFrame_q.kind <= FIS_REGISTER;
          txFrame_q.interruptFlag <= 1'b1;
          txFrame_q.aborted <= abort_d;
        end
        default: txFrame_q <= '0;
      endcase
    end
  end

  // APB slave: one wait cycle, then data and pready together
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q <= 32'h0;
      if (psel && penable && !pready_q && !pwrite) begin
        case (paddr)
          ADDR_LENGTH: prdata_q <= length_q;
          ADDR_STATE: prdata_q <= 32'(state_q);
          ADDR_REMAIN: prdata_q <= remain_q;
          ADDR_INT_STAT: prdata_q <= 32'(intStat_q);
          ADDR_INT_MASK: prdata_q <= 32'(intMask_q);
          default: prdata_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      length_q <= LENGTH_RESET;
      intMask_q <= INT_MASK_RESET;
    end else begin
      if (apbWrite && paddr == ADDR_LENGTH && state_q == device_idle_state) begin
        length_q <= pwdata;
      end
      if (apbWrite && paddr == ADDR_INT_MASK) begin
        intMask_q <= pwdata[INT_W-1:0];
      end
    end
  end

  // sticky status, a new event wins over a same-cycle clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      intStat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (apbWrite && paddr == ADDR_INT_STAT) begin
        intStat_q <= (intStat_q & ~pwdata[INT_W-1:0]) | intEvent;
      end else begin
        intStat_q <= intStat_q | intEvent;
      end
      irq_q <= |(intStat_q & intMask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign txFrame = txFrame_q;
  assign rxExpect = rxExpect_q;
  assign irq = irq_q;

  chk_read_abort_path: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_prepare_state && abortReq |=> state_q == pio_read_error_state
    ##1 txFrame.kind == FIS_REGISTER) else $error("read abort not reported");
  chk_read_setup_bits: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_setup_state |-> txFrame.valid && !txFrame.initBusy
    && txFrame.initDataReq && txFrame.interruptFlag) else $error("read setup bits wrong");
  chk_read_end_status: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_setup_state |-> txFrame.endBusy == (remain_q != 32'(blkLen_q))
    && !txFrame.endDataReq) else $error("read end status wrong");
  chk_read_then_data: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_setup_state && frameSent |=> txFrame.kind == FIS_DATA
    && txFrame.byteCount == $past(blkLen_q)) else $error("data frame missing");
  chk_read_completion: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_transmit_state && frameSent && remain_q == 32'(blkLen_q)
    |=> state_q == device_idle_state ##1 !txFrame.valid) else $error("no idle");
  chk_write_first_int: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_write_setup_state |-> txFrame.interruptFlag == !first_q
    && txFrame.endBusy && txFrame.byteCount == blkLen_q) else $error("write setup");
  chk_write_receive: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_write_receive_state && dataReceived |=> state_q == pio_write_prepare_state
    && remain_q == $past(remain_q) - 32'($past(blkLen_q))) else $error("write recv");
  chk_write_finish: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_write_prepare_state && remain_q == 32'h0
    |=> state_q == pio_write_status_state) else $error("write not finished");
  chk_status_to_idle: assert property (@(posedge mclk) disable iff (!resetn)
    txFrame.kind == FIS_REGISTER && frameSent |=> state_q == device_idle_state
    && !txFrame.valid) else $error("status frame not closing");
  chk_dma_size_cap: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == dma_read_send_state |-> txFrame.kind == FIS_DATA
    && txFrame.byteCount <= MAX_LEN && txFrame.byteCount != '0) else $error("dma size");
  chk_dma_finish: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == dma_read_prepare_state && (abortReq || remain_q == 32'h0)
    |=> state_q == dma_read_status_state) else $error("dma not finished");
  chk_read_prepare_go: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_prepare_state && !abortReq && blockReady
    |=> state_q == pio_read_setup_state) else $error("read block not started");
  chk_read_block_fit: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_setup_state |-> txFrame.byteCount != '0
    && txFrame.byteCount <= MAX_LEN && 32'(txFrame.byteCount) <= remain_q)
    else $error("read block size wrong");
  chk_read_more_blocks: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_read_transmit_state && frameSent && remain_q != 32'(blkLen_q)
    |=> state_q == pio_read_prepare_state
    && remain_q == $past(remain_q) - 32'($past(blkLen_q))) else $error("read not resumed");
  chk_write_prepare_go: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_write_prepare_state && !abortReq && remain_q != 32'h0 && blockReady
    |=> state_q == pio_write_setup_state) else $error("write block not started");
  chk_write_init_bits: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_write_setup_state |-> txFrame.valid && txFrame.kind == FIS_PIO_SETUP
    && !txFrame.initBusy && txFrame.initDataReq) else $error("write init bits wrong");
  chk_write_end_status: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == pio_write_setup_state |-> !txFrame.endDataReq && txFrame.byteCount != '0
    && 32'(txFrame.byteCount) <= remain_q) else $error("write end status wrong");
  chk_rx_window: assert property (@(posedge mclk) disable iff (!resetn)
    rxExpect == (state_q == pio_write_receive_state)) else $error("receive window wrong");
  chk_status_frame: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q == pio_read_error_state || state_q == pio_write_status_state
    || state_q == dma_read_status_state) |-> txFrame.valid && txFrame.kind == FIS_REGISTER
    && txFrame.interruptFlag && txFrame.aborted == abort_q) else $error("status frame wrong");
  chk_dma_prepare_go: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == dma_read_prepare_state && !abortReq && remain_q != 32'h0 && blockReady
    |=> state_q == dma_read_send_state) else $error("dma frame not started");
  chk_dma_back: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == dma_read_send_state && frameSent |=> state_q == dma_read_prepare_state)
    else $error("dma not back to prepare");
  chk_cmd_load: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == device_idle_state && startCmd |=> state_q != device_idle_state
    && remain_q == $past(length_q)) else $error("command not loaded");
endmodule

// ==== tb/device_pio_dma_transfer_fsm_test.sv ====
/*
  Self-checking bench for the transfer sequencer: APB master, data path and
  transport model. Assumes the package constants and a 64-byte block limit.
*/
module device_pio_dma_transfer_fsm_test
  import dpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MB = 64;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, blockReady, abortReq;
  logic frameSent, dataReceived, rxExpect, irq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] waitCycles;
  dpt_frame_t txFrame;
  dpt_frame_t frames[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rxCount = 0;

  always #2.5 mclk = ~mclk;

  dpt_transfer_fsm #(.MAX_BLOCK(MB)) DUT (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .blockReady(blockReady), .abortReq(abortReq),
    .frameSent(frameSent), .dataReceived(dataReceived), .txFrame(txFrame),
    .rxExpect(rxExpect), .irq(irq));
  dpt_host_model host (.mclk(mclk), .resetn(resetn), .waitCycles(waitCycles),
    .txFrame(txFrame), .rxExpect(rxExpect), .frameSent(frameSent),
    .dataReceived(dataReceived));

  always @(posedge mclk) begin
    if (frameSent === 1'b1 && txFrame.valid === 1'b1) frames.push_back(txFrame);
    if (dataReceived === 1'b1 && rxExpect === 1'b1) rxCount++;
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("counts: %0d mismatches, %0d comparisons", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the bench timeout ends a hung transfer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // full frame image with valid set; flags run from initBusy down to aborted
  function automatic logic [31:0] fr(dpt_fis_t k, logic [5:0] fl, logic [LEN_W-1:0] bc);
    return 32'({1'b1, k, fl, bc});
  endfunction
  function automatic logic [31:0] kb(dpt_frame_t f);
    return 32'({f.kind, f.byteCount});
  endfunction
  function automatic logic [31:0] ka(dpt_frame_t f);
    return 32'({f.kind, f.interruptFlag, f.aborted});
  endfunction

  task automatic run(input logic [1:0] cls, input logic [31:0] len);
    frames.delete();
    rxCount = 0;
    apb(1'b1, ADDR_INT_STAT, 32'h3);
    apb(1'b1, ADDR_LENGTH, len);
    apb(1'b1, ADDR_CMD, 32'(cls));
    do begin
      apb(1'b0, ADDR_STATE, 32'h0);
    end while (rd !== 32'h0);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_LENGTH, 32'h0);
    check(rd, LENGTH_RESET);
    apb(1'b0, ADDR_INT_MASK, 32'h0);
    check(rd, 32'(INT_MASK_RESET));
    apb(1'b0, 8'h20, 32'h0);
    check({rd[30:0], err}, 32'h1);
    // zero length: command refused, sequencer stays idle
    apb(1'b1, ADDR_CMD, 32'h1);
    apb(1'b0, ADDR_STATE, 32'h0);
    check(rd, 32'h0);
    $display("test regs finished");
  endtask

  task automatic t_read();
    waitCycles <= 4'h0;
    apb(1'b1, ADDR_INT_MASK, 32'h3);
    run(2'h1, 32'd100);
    check(frames.size(), 4);
    check(32'(frames[0]), fr(FIS_PIO_SETUP, 6'h1A, 14'd64));
    check(kb(frames[1]), 32'({FIS_DATA, 14'd64}));
    check(32'(frames[2]), fr(FIS_PIO_SETUP, 6'h12, 14'd36));
    check(kb(frames[3]), 32'({FIS_DATA, 14'd36}));
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    check(rd, 32'h1);
    check(32'(irq), 32'h1);
    $display("test pio read finished");
  endtask

  task automatic t_write();
    waitCycles <= 4'h2;
    run(2'h2, 32'd100);
    check(frames.size(), 3);
    check(32'(frames[0]), fr(FIS_PIO_SETUP, 6'h18, 14'd64));
    check(32'(frames[1]), fr(FIS_PIO_SETUP, 6'h1A, 14'd36));
    check(rxCount, 2);
    check(ka(frames[2]), 32'({FIS_REGISTER, 2'b10}));
    $display("test pio write finished");
  endtask

  task automatic t_dma();
    waitCycles <= 4'h3;
    run(2'h3, 32'd200);
    check(frames.size(), 5);
    for (int i = 0; i < 4; i++) begin
      check(kb(frames[i]), 32'({FIS_DATA, (i < 3) ? 14'd64 : 14'd8}));
    end
    check(ka(frames[4]), 32'({FIS_REGISTER, 2'b10}));
    $display("test dma read finished");
  endtask

  task automatic t_abort();
    waitCycles <= 4'h1;
    blockReady <= 1'b0;
    abortReq <= 1'b1;
    apb(1'b1, ADDR_INT_MASK, 32'h1);
    run(2'h1, 32'd100);
    check(frames.size(), 1);
    check(ka(frames[0]), 32'({FIS_REGISTER, 2'b11}));
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    check(rd, 32'h2);
    check(32'(irq), 32'h0);
    run(2'h2, 32'd100);
    check(ka(frames[0]), 32'({FIS_REGISTER, 2'b11}));
    run(2'h3, 32'd100);
    check(ka(frames[0]), 32'({FIS_REGISTER, 2'b11}));
    apb(1'b0, ADDR_INT_STAT, 32'h0);
    check(rd, 32'h2);
    abortReq <= 1'b0;
    blockReady <= 1'b1;
    $display("test abort finished");
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    waitCycles = 4'h0;
    blockReady = 1'b1;
    abortReq = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_read();
    t_write();
    t_dma();
    t_abort();
    wrap_up();
  end
endmodule

// ==== tb/dpt_host_model.sv ====
/*
  Transport-layer model of the far side for the transfer sequencer.
  Assumes one clock shared with the device; waitCycles sets how slowly it answers.
*/
module dpt_host_model
  import dpt_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] waitCycles,
  input wire dpt_frame_t txFrame,
  input wire logic rxExpect,
  output logic frameSent,
  output logic dataReceived
);
  logic [3:0] txCnt_q;
  logic [3:0] rxCnt_q;
  // outgoing frame taken after waitCycles+1 cycles of valid
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frameSent <= 1'b0;
      txCnt_q <= 4'h0;
    end else begin
      frameSent <= 1'b0;
      if (frameSent) begin
        txCnt_q <= 4'h0;
      end else if (txFrame.valid) begin
        if (txCnt_q == waitCycles) begin
          frameSent <= 1'b1;
          txCnt_q <= 4'h0;
        end else begin
          txCnt_q <= txCnt_q + 4'h1;
        end
      end
    end
  end
  // host data frame offered while the device waits for it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dataReceived <= 1'b0;
      rxCnt_q <= 4'h0;
    end else begin
      dataReceived <= 1'b0;
      if (dataReceived) begin
        rxCnt_q <= 4'h0;
      end else if (rxExpect) begin
        if (rxCnt_q == waitCycles) begin
          dataReceived <= 1'b1;
          rxCnt_q <= 4'h0;
        end else begin
          rxCnt_q <= rxCnt_q + 4'h1;
        end
      end
    end
  end
endmodule
